// ==== fssl_frame_source.sv ====
// Behavioural frame sync recognizer and channel sorter for the search/lock block.
// Assumes the block's clock and reset; eight cycles per channel, sixteen channels.
`timescale 1ns/1ps
module fssl_frame_source (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] mode_in,   // 0 silent, 1 in bracket, 2 outside
    input wire logic sorter_reset_in, // Realign pulse from the block
    output logic recog_out,
    output logic bracket_out,
    output logic chan15_out
);
    // ****************************************
    // Channel count
    // ****************************************
    logic [3:0] ch_ff; // Channel number
    logic [2:0] ph_ff; // Cycle within channel
    // Realign lands past the pulse cycles, so one pulse is never seen twice
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ch_ff <= 4'h0;
            ph_ff <= 3'h0;
        end else if (sorter_reset_in) begin
            ch_ff <= 4'h0;
            ph_ff <= 3'h6;
        end else begin
            ph_ff <= ph_ff + 3'h1;
            ch_ff <= (ph_ff == 3'h7) ? ch_ff + 4'h1 : ch_ff;
        end
    end
    // Bracket leads the pulse by four cycles so the block samples it settled
    assign bracket_out = (ch_ff == 4'h0);
    assign chan15_out = (ch_ff == 4'hf) && !ph_ff[2];
    assign recog_out = (ph_ff[2:1] == 2'h2) && ((mode_in == 2'h1 && ch_ff == 4'h0) || (mode_in == 2'h2 && ch_ff == 4'h5));
endmodule : fssl_frame_source

// ==== fssl_pkg.sv ====
// Constants and types for the frame sync search and lock block.
// Assumes a single 20 MHz clock and frame-rate pulse inputs.
package fssl_pkg;
    // ****************************************
    // Widths and timing
    // ****************************************
    localparam int DEC_W = 4;              // Decision counter width
    localparam int LOSS_W = 5;             // Loss counter width
    localparam int CLK_HZ = 20000000;      // Clock rate
    localparam int FORCE_US = 200;         // Forced search pulse, microseconds
    localparam int FORCE_CYC = FORCE_US * (CLK_HZ / 1000000); // Longest time rounds down
    localparam int FORCE_W = 13;           // Width holding FORCE_CYC
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [DEC_W-1:0] DEC_RST = 4'h0;
    localparam logic [LOSS_W-1:0] LOSS_RST = 5'h00;
    localparam logic [FORCE_W-1:0] FORCE_RST = 13'h0000;
    // Forced search pulse states
    typedef enum logic [1:0] {FS_IDLE, FS_ARMED, FS_PULSE} fssl_force_t;
endpackage : fssl_pkg

// ==== fssl_search_lock.sv ====
// Search and lock decision logic for a telemetry decommutator.
// Assumes recognition, bracket and channel-15 inputs come from pins and are synchronised here.
// Limits are plain static ports; a width parameter stands in for the forced-search one-shot.
`timescale 1ns/1ps
module fssl_search_lock #(
    parameter int FORCE_CYCLES = fssl_pkg::FORCE_CYC // Shorten for simulation
) (
    input wire logic clk_in,                              // 20 MHz clock
    input wire logic reset_n_in,                          // Async reset, low
    input wire logic recog_in,                            // Frame sync recognition level
    input wire logic bracket_in,                          // Channel-zero bracket level
    input wire logic chan15_in,                           // Expected channel 15 level
    input wire logic manual_reset_in,                     // Push-button, level
    input wire logic [fssl_pkg::DEC_W-1:0] agree_limit_select_in,    // Agree limit minus one
    input wire logic [fssl_pkg::DEC_W-1:0] disagree_limit_select_in, // Disagree limit minus one
    output logic lock_out,                                // Lock indicator
    output logic search_out,                              // Search indicator
    output logic print_enable_out,                        // Printout permitted
    output logic search_start_out,                        // One cycle at search start
    output logic sorter_reset_out,                        // Channel sorter realign pulse
    output logic gate_armed_out,                          // Realign gate open
    output logic lock_lost_out,                           // Loss overflow flag
    output logic [fssl_pkg::DEC_W-1:0] agree_count_out,   // In-sync count
    output logic [fssl_pkg::DEC_W-1:0] disagree_count_out // Out-of-sync count
);
    import fssl_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [3:0] sync1_ff; // First stage, read only by the second
    logic [3:0] sync2_ff; // Second stage
    logic [3:0] prev_ff;  // For rising edges
    logic [3:0] nxt_sync1;
    logic [3:0] nxt_sync2;
    logic [3:0] nxt_prev;
    logic [3:0] rise;     // Rising edge of each input

    // Synchroniser next values
    always_comb begin
        nxt_sync1 = {manual_reset_in, chan15_in, bracket_in, recog_in};
        nxt_sync2 = sync1_ff;
        nxt_prev = sync2_ff;
    end

    // Synchroniser registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            prev_ff <= 4'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff <= nxt_prev;
        end
    end

    assign rise = sync2_ff & ~prev_ff;

    // Recognition, channel-15 and push-button act on rising edges; the bracket stays a level
    // and shares the same two-stage delay, so it lines up with the recognition edge
    logic recog_p;   // Recognition pulse event
    logic bracket_l; // Bracket level, synchronised
    logic chan15_p;  // Channel 15 event
    logic manual_p;  // Manual reset event
    assign recog_p = rise[0];
    assign bracket_l = sync2_ff[1];
    assign chan15_p = rise[2];
    assign manual_p = rise[3];

    // ****************************************
    // Decision and control state
    // ****************************************
    logic [DEC_W-1:0] agree_ff;
    logic [DEC_W-1:0] disagree_ff;
    logic [LOSS_W-1:0] loss_ff;
    logic lock_ff;
    logic armed_ff;
    logic lost_ff;
    logic sorter_rst_ff;
    logic start_ff;
    fssl_force_t force_ff;
    logic [FORCE_W-1:0] force_cnt_ff;
    logic [DEC_W-1:0] nxt_agree;
    logic [DEC_W-1:0] nxt_disagree;
    logic [LOSS_W-1:0] nxt_loss;
    logic nxt_lock;
    logic nxt_armed;
    logic nxt_lost;
    logic nxt_sorter_rst;
    logic nxt_start;
    fssl_force_t nxt_force;
    logic [FORCE_W-1:0] nxt_force_cnt;

    logic agree_dec;    // In-sync decision
    logic disagree_dec; // Out-of-sync decision
    logic agree_hit;    // Agree counter at limit
    logic disagree_hit; // Disagree counter at limit
    logic force_srch;   // Forced search from loss or manual
    logic realign;      // Realign pulse this cycle

    // Coincidence: decisions exist only with a recognition pulse
    assign agree_dec = recog_p & bracket_l;
    assign disagree_dec = recog_p & ~bracket_l;
    // Limit reached when the count held before this decision equals the selected value; select n gives n+1 (1..16)
    // A realigning pulse is not counted and a forced search discards decisions, so neither
    // may reach a limit; otherwise a limit of one would lock on the very pulse that moves
    // the channel sorter, before any evaluation has taken place
    assign agree_hit = agree_dec && !realign && !force_srch
        && (agree_ff == agree_limit_select_in);
    assign disagree_hit = disagree_dec && !realign && !force_srch
        && (disagree_ff == disagree_limit_select_in);
    // The armed step counts as forced too, so lock drops in the cycle the start marker rises
    assign force_srch = (force_ff != FS_IDLE) || manual_p;
    // Armed gate fires on first recognition pulse
    assign realign = armed_ff && recog_p;

    // Next state of the decision logic
    always_comb begin
        nxt_agree = agree_ff;
        nxt_disagree = disagree_ff;
        nxt_loss = loss_ff;
        nxt_lock = lock_ff;
        nxt_armed = armed_ff;
        nxt_lost = lost_ff;
        nxt_sorter_rst = realign;
        nxt_start = 1'b0;
        nxt_force = force_ff;
        nxt_force_cnt = force_cnt_ff;
        // Count decisions separately
        if (agree_dec) begin
            nxt_agree = agree_ff + 4'h1;
        end
        if (disagree_dec) begin
            nxt_disagree = disagree_ff + 4'h1;
        end
        // Limits: a pulse is one decision, so both cannot hit together
        if (agree_hit) begin
            nxt_agree = DEC_RST;
            nxt_disagree = DEC_RST;
            nxt_lock = 1'b1;
        end else if (disagree_hit) begin
            nxt_agree = DEC_RST;
            nxt_disagree = DEC_RST;
            nxt_lock = 1'b0;
            nxt_armed = 1'b1;
        end
        // Realign clears counters; the realigning pulse itself is not counted
        if (realign) begin
            nxt_agree = DEC_RST;
            nxt_disagree = DEC_RST;
            // A forced search further down may reopen the gate in this same cycle
            nxt_armed = 1'b0;
        end
        // Flag is taken as the forced pulse starts; written before the set below so that
        // an overflow landing in that same cycle still wins
        if (force_ff == FS_ARMED) begin
            nxt_lost = 1'b0;
        end
        // Loss counter: cleared by recognition, counts channel-15 marks
        if (recog_p) begin
            nxt_loss = LOSS_RST;
        end else if (chan15_p) begin
            nxt_loss = loss_ff + 5'h01;
            if (loss_ff == {LOSS_W{1'b1}}) begin
                nxt_lost = 1'b1;
            end
        end
        // Forced search pulse sequencer
        case (force_ff)
            FS_IDLE: begin
                if (lost_ff) begin
                    nxt_force = FS_ARMED;
                end
            end
            FS_ARMED: begin
                // Flag taken above; pulse starts
                nxt_force = FS_PULSE;
                nxt_force_cnt = FORCE_RST;
            end
            FS_PULSE: begin
                // Hold for the 200 us width
                nxt_force_cnt = force_cnt_ff + 13'h0001;
                if (force_cnt_ff == FORCE_W'(FORCE_CYCLES - 1)) begin
                    nxt_force = FS_IDLE;
                end
            end
            default: begin
                nxt_force = FS_IDLE;
            end
        endcase
        // Forced search behaves as an automatic one
        if (force_srch) begin
            nxt_lock = 1'b0;
            nxt_armed = 1'b1;
            nxt_agree = DEC_RST;
            nxt_disagree = DEC_RST;
        end
        // One marker per entry: a loss-forced entry marks at the armed step, where lock also drops; a manual one on its push-button edge
        // Search start marker on the lock to search transition, on any disagree limit (also while searching) or on a fresh forced entry
        if ((lock_ff && !nxt_lock) || disagree_hit || manual_p || (force_ff == FS_ARMED)) begin
            nxt_start = 1'b1;
        end
    end

    // Every flag resets to a constant; nothing is loaded from an input during reset
    // Decision registers; power-up searching with gate armed
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            agree_ff <= DEC_RST;
            disagree_ff <= DEC_RST;
            loss_ff <= LOSS_RST;
            lock_ff <= 1'b0;
            armed_ff <= 1'b1;
            lost_ff <= 1'b0;
            sorter_rst_ff <= 1'b0;
            start_ff <= 1'b0;
            force_ff <= FS_IDLE;
            force_cnt_ff <= FORCE_RST;
        end else begin
            agree_ff <= nxt_agree;
            disagree_ff <= nxt_disagree;
            loss_ff <= nxt_loss;
            lock_ff <= nxt_lock;
            armed_ff <= nxt_armed;
            lost_ff <= nxt_lost;
            sorter_rst_ff <= nxt_sorter_rst;
            start_ff <= nxt_start;
            force_ff <= nxt_force;
            force_cnt_ff <= nxt_force_cnt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Indicators and printout follow the one lock flag, so they can never disagree
    assign lock_out = lock_ff;
    assign search_out = ~lock_ff;
    assign print_enable_out = lock_ff;
    assign search_start_out = start_ff;
    assign sorter_reset_out = sorter_rst_ff;
    assign gate_armed_out = armed_ff;
    assign lock_lost_out = lost_ff;
    assign agree_count_out = agree_ff;
    assign disagree_count_out = disagree_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    agree_lock_a: assert property (agree_hit && !force_srch |=> lock_ff && agree_ff == DEC_RST)
        else $error("agree limit did not lock");
    disagree_srch_a: assert property (disagree_hit && !realign |=> !lock_ff && armed_ff)
        else $error("disagree limit did not search");
    only_agree_a: assert property ($rose(lock_ff) |-> $past(agree_hit))
        else $error("lock set without agree limit");
    no_recog_a: assert property (!recog_p && !force_srch |=> $stable(agree_ff) && $stable(disagree_ff))
        else $error("decision counters moved without pulse");
    realign_pulse_a: assert property (armed_ff && recog_p && !disagree_hit && !force_srch
        |=> sorter_reset_out && !armed_ff && agree_ff == DEC_RST)
        else $error("realign did not fire or disarm");
    loss_clear_a: assert property (recog_p |=> loss_ff == LOSS_RST)
        else $error("loss counter not cleared");
    force_width_a: assert property ($rose(force_ff == FS_PULSE) |-> (force_ff == FS_PULSE)[*8])
        else $error("forced search pulse too short");
    manual_srch_a: assert property (manual_p |=> !lock_ff && armed_ff && search_start_out)
        else $error("manual reset did not search");
    print_gate_a: assert property (print_enable_out == lock_ff && search_out == !lock_out)
        else $error("printout or indicators wrong");
    start_mark_a: assert property ($fell(lock_ff) |-> search_start_out)
        else $error("search start not marked");

    lock_c: cover property ($rose(lock_ff));
    loss_c: cover property (force_ff == FS_PULSE);
    realign_c: cover property (sorter_reset_out);
    relock_c: cover property ($fell(lock_ff) ##[1:1000] $rose(lock_ff));
    manual_c: cover property (manual_p);

    // ****************************************
    // Counting, loss, forced search and sorter reset guards
    // ****************************************
    // Each plain decision moves its own counter by one; a counter that skipped
    // would shift the programmed ratio with no visible sign
    agree_step_a: assert property (agree_dec && !agree_hit && !realign && !force_srch
        |=> agree_ff == $past(agree_ff) + 4'h1)
        else $error("agree counter did not step");
    disagree_step_a: assert property (disagree_dec && !disagree_hit && !realign && !force_srch
        |=> disagree_ff == $past(disagree_ff) + 4'h1)
        else $error("disagree counter did not step");
    // The overflow set wins over the clear, so a loss is never dropped
    lost_set_a: assert property (chan15_p && !recog_p && loss_ff == {LOSS_W{1'b1}} |=> lost_ff)
        else $error("loss overflow not flagged");
    loss_step_a: assert property (chan15_p && !recog_p |=> loss_ff == $past(loss_ff) + 5'h01)
        else $error("loss counter did not step");
    // While the forced pulse runs the block is held in search with the gate open
    force_hold_a: assert property (force_ff == FS_PULSE |=> !lock_ff && armed_ff && agree_ff == DEC_RST)
        else $error("forced search not held");
    // A sorter reset standing two cycles would move the channel count twice
    sorter_once_a: assert property (sorter_reset_out |=> !sorter_reset_out)
        else $error("sorter reset stood too long");
endmodule : fssl_search_lock

// ==== tb_fssl_search_lock.sv ====
// Self-checking bench for the frame sync search and lock block.
// Assumes the frame source model; notes queue expected mode events.
`timescale 1ns/1ps
module tb_fssl_search_lock;
    import fssl_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_in = 1'b0, reset_n_in = 1'b0, manual_reset_in = 1'b0;
    logic [1:0] mode = 2'h0; // Source pattern
    logic [DEC_W-1:0] agree_sel, disagree_sel; // Drawn at random, redrawn mid-run
    logic recog, bracket, chan15, lock_o, search_o, print_o, ss_o, sr_o, armed_o, lost_o, prev_lock, prev_lost;
    logic [DEC_W-1:0] agree_o, disagree_o;
    logic [13:0] obs; // Observed mode, marker and count vector
    logic [13:0] exp_q[$]; // Expected event vectors
    int failures = 0, num_checks = 0, a_lim, d_lim, lost_n = 0;
    // Short forced pulse keeps the run brief
    fssl_search_lock #(.FORCE_CYCLES(10)) i_fssl_search_lock (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .recog_in(recog), .bracket_in(bracket), .chan15_in(chan15), .manual_reset_in(manual_reset_in),
        .agree_limit_select_in(agree_sel), .disagree_limit_select_in(disagree_sel), .lock_out(lock_o),
        .search_out(search_o), .print_enable_out(print_o), .search_start_out(ss_o), .sorter_reset_out(sr_o),
        .gate_armed_out(armed_o), .lock_lost_out(lost_o), .agree_count_out(agree_o), .disagree_count_out(disagree_o));
    fssl_frame_source i_fssl_frame_source (.clk_in(clk_in), .reset_n_in(reset_n_in), .mode_in(mode),
        .sorter_reset_in(sr_o), .recog_out(recog), .bracket_out(bracket), .chan15_out(chan15));
    assign obs = {lock_o, search_o, print_o, armed_o, sr_o, ss_o, agree_o, disagree_o};
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [13:0] seen, input logic [13:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic finish_test;
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // Wait for a source pulse, then for the block's answer to land
    task automatic pulse;
        @(posedge recog);
        repeat (5) @(negedge clk_in);
    endtask : pulse
    // New limits at a rising edge while both counters stand cleared
    task automatic pick_limits;
        @(posedge clk_in);
        a_lim = $urandom % 16 + 1;
        d_lim = $urandom % 16 + 1;
        agree_sel <= 4'(a_lim - 1);
        disagree_sel <= 4'(d_lim - 1);
    endtask : pick_limits
    // Realign on the first pulse, then count agreements up to lock
    task automatic acquire;
        @(posedge clk_in) mode <= 2'h1;
        exp_q.push_back(14'h1200);
        pulse();
        for (int k = 1; k <= a_lim; k++) begin
            if (k == a_lim) exp_q.push_back(14'h2800);
            pulse();
            if (k < a_lim) check({10'h0, agree_o}, k[13:0]);
        end
    endtask : acquire
    // ****************************************
    // Event monitor: lock rise or either pulse
    // ****************************************
    initial begin
        prev_lock = 1'b0;
        prev_lost = 1'b0;
        forever begin
            @(negedge clk_in);
            if (reset_n_in && (sr_o || ss_o || (lock_o && !prev_lock))) begin
                if (exp_q.size() == 0) begin
                    check(obs, 14'h3fff);
                end else begin
                    check(obs, exp_q.pop_front());
                end
            end
            if (reset_n_in && lost_o && !prev_lost) begin
                lost_n++;
            end
            prev_lock = lock_o;
            prev_lost = lost_o;
        end
    end
    initial begin
        repeat (50000) @(posedge clk_in);
        failures++;
        finish_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(58));
        pick_limits();
        repeat (7) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(negedge clk_in);
        check(obs, 14'h1400);
        acquire();
        // Disagreements while locked drop back to search
        @(posedge clk_in) mode <= 2'h2;
        for (int k = 1; k <= d_lim; k++) begin
            if (k == d_lim) exp_q.push_back(14'h1500);
            pulse();
            if (k < d_lim) check({10'h0, disagree_o}, k[13:0]);
        end
        acquire();
        // Silence: no decisions, then loss overflow forces search
        @(posedge clk_in) mode <= 2'h0;
        repeat (300) @(negedge clk_in);
        check({6'h0, agree_o, disagree_o}, 14'h0);
        exp_q.push_back(14'h1500);
        repeat (32 * 128) @(negedge clk_in);
        pick_limits();
        acquire();
        // Manual push-button acts like an automatic search
        @(posedge clk_in) mode <= 2'h0;
        exp_q.push_back(14'h1500);
        @(posedge clk_in) manual_reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        manual_reset_in <= 1'b0;
        repeat (20) @(negedge clk_in);
        acquire();
        repeat (10) @(negedge clk_in);
        check(14'(exp_q.size()), 14'h0);
        check(14'(lost_n), 14'h1);
        finish_test();
    end
endmodule : tb_fssl_search_lock
